// ### core/ads_alarm_access.sv
// Alarm delay, silence, accept and direct setpoint access with an AXI4-Lite register file.
`timescale 1ns/100ps
`default_nettype none
`include "ads_defines.svh"

module ads_alarm_access
    import ads_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `ADS_TICK_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_btn_step,
    input wire logic i_btn_up,
    input wire logic i_btn_down,
    input wire logic i_btn_enter,
    input wire logic [1:0] i_alarm_cond,
    input wire logic i_setpoint_access_menu_open,
    output logic o_setpoint_access_menu_done,
    output logic [1:0] o_alarm_out,
    output logic [1:0] o_annun_on,
    output logic [1:0] o_annun_flash,
    output ads_disp_t o_disp,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Step one BCD digit up or down, wrapping within 0 to 9.
    function automatic logic [15:0] bcd_adj(input logic [15:0] v, input logic [1:0] d,
                                            input logic up);
        logic [15:0] r;
        logic [3:0] n;
        r = v;
        n = v[d*4 +: 4];
        if (up) begin
            n = (n >= 4'h9) ? 4'h0 : n + 4'h1;
        end else begin
            n = (n == 4'h0 || n > 4'h9) ? 4'h9 : n - 4'h1;
        end
        r[d*4 +: 4] = n;
        return r;
    endfunction

    // Limit a written time to the 3600 second ceiling.
    function automatic logic [11:0] clamp_s(input logic [15:0] v);
        return (v > {4'h0, `ADS_MAX_SECONDS}) ? `ADS_MAX_SECONDS : v[11:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Button synchronisers and press edges.
    logic [3:0] btn_s1_r, btn_s2_r, btn_s3_r;
    logic [3:0] press;
    logic [3:0] held;

    // Pins are asynchronous; the first stage feeds only the second.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            btn_s1_r <= 4'h0;
            btn_s2_r <= 4'h0;
            btn_s3_r <= 4'h0;
        end else begin
            btn_s1_r <= {i_btn_enter, i_btn_down, i_btn_up, i_btn_step};
            btn_s2_r <= btn_s1_r;
            btn_s3_r <= btn_s2_r;
        end
    end
    assign held = btn_s2_r;
    assign press = btn_s2_r & ~btn_s3_r;
    wire p_step = press[0];
    wire p_up = press[1];
    wire p_down = press[2];
    wire p_enter = press[3];
    wire any_press = |press;

    ////////////////////////////////////////////////////////////////////////////////
    // One-second tick.
    logic [31:0] tick_cnt_r;
    logic tick_r;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            tick_cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
            tick_cnt_r <= 32'h0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Settings held in registers.
    logic access_en_r;
    logic [1:0] sense_r;
    logic [15:0] code_r;
    logic [11:0] delay_r [2];
    logic [11:0] sil_r [2];
    logic [15:0] sp_r [2];
    ads_menu_t menu_r;
    logic sel_r;
    logic [15:0] edit_r;
    logic [1:0] digit_r;
    logic en_edit_r;
    logic [3:0] idle_s_r;

    wire silence_armed = (sil_r[0] != 12'h0) || (sil_r[1] != 12'h0);
    wire accept = (menu_r == ADS_OPER) && p_step && !held[1] && silence_armed;
    wire setpoint_access_menu_req = (menu_r == ADS_OPER) && held[0] && held[1] && (p_step || p_up);

    ////////////////////////////////////////////////////////////////////////////////
    // Alarm timing per channel.
    ads_alarm_t al_r [2];
    logic [11:0] al_cnt_r [2];

    for (genvar g = 0; g < 2; g++) begin : g_alarm
        // Delay and silence count whole seconds; a condition lost before the output
        // fires cancels the pending alarm.
        always_ff @(posedge i_ref_clk or posedge i_reset) begin
            if (i_reset) begin
                al_r[g] <= ADS_AL_IDLE;
                al_cnt_r[g] <= 12'h0;
            end else begin
                unique case (al_r[g])
                    ADS_AL_IDLE: begin
                        al_cnt_r[g] <= delay_r[g];
                        if (i_alarm_cond[g]) begin
                            al_r[g] <= (delay_r[g] == 12'h0) ? ADS_AL_ACTIVE : ADS_AL_PEND;
                        end
                    end
                    ADS_AL_PEND: begin
                        if (!i_alarm_cond[g]) begin
                            al_r[g] <= ADS_AL_IDLE;
                        end else if (tick_r) begin
                            al_cnt_r[g] <= al_cnt_r[g] - 12'h1;
                            if (al_cnt_r[g] == 12'h1) begin
                                al_r[g] <= ADS_AL_ACTIVE;
                            end
                        end
                    end
                    ADS_AL_ACTIVE: begin
                        al_cnt_r[g] <= sil_r[g];
                        if (!i_alarm_cond[g]) begin
                            al_r[g] <= ADS_AL_IDLE;
                        end else if (accept && sil_r[g] != 12'h0) begin
                            al_r[g] <= ADS_AL_SILENCE;
                        end
                    end
                    ADS_AL_SILENCE: begin
                        if (tick_r) begin
                            al_cnt_r[g] <= al_cnt_r[g] - 12'h1;
                            if (al_cnt_r[g] <= 12'h1) begin
                                al_r[g] <= i_alarm_cond[g] ? ADS_AL_ACTIVE : ADS_AL_IDLE;
                            end
                        end
                    end
                    default: al_r[g] <= ADS_AL_IDLE;
                endcase
            end
        end

        // Outputs come from flip-flops so the switch never glitches.
        always_ff @(posedge i_ref_clk or posedge i_reset) begin
            if (i_reset) begin
                o_alarm_out[g] <= 1'b0;
                o_annun_on[g] <= 1'b0;
                o_annun_flash[g] <= 1'b0;
            end else begin
                o_alarm_out[g] <= (al_r[g] == ADS_AL_ACTIVE) ^ sense_r[g];
                o_annun_on[g] <= (al_r[g] != ADS_AL_IDLE);
                o_annun_flash[g] <= (al_r[g] == ADS_AL_PEND) ||
                                    (al_r[g] == ADS_AL_SILENCE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Operator menu.
    wire direct = (menu_r == ADS_CODE_PROMPT) || (menu_r == ADS_CODE_EDIT) ||
                  (menu_r == ADS_SP_PROMPT) || (menu_r == ADS_SP_EDIT);
    logic sp_store;
    logic code_store;
    logic en_store;

    // Menu walk; stores are flagged here and applied in the register process.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            menu_r <= ADS_OPER;
            sel_r <= 1'b0;
            edit_r <= 16'h0000;
            digit_r <= 2'h0;
            en_edit_r <= 1'b0;
            idle_s_r <= 4'h0;
            o_setpoint_access_menu_done <= 1'b0;
        end else begin
            o_setpoint_access_menu_done <= 1'b0;
            idle_s_r <= (any_press || !direct) ? 4'h0 : idle_s_r + {3'h0, tick_r};
            if (direct && idle_s_r >= `ADS_IDLE_TIMEOUT_S) begin
                menu_r <= ADS_OPER;
            end else begin
                unique case (menu_r)
                    ADS_OPER: begin
                        if (i_setpoint_access_menu_open) begin
                            menu_r <= ADS_CFG_ACCESS_ENABLE;
                        end else if (setpoint_access_menu_req && access_en_r) begin
                            sel_r <= 1'b0;
                            edit_r <= 16'h0000;
                            digit_r <= 2'h0;
                            menu_r <= (code_r == 16'h0000) ? ADS_SP_PROMPT :
                                      ADS_CODE_PROMPT;
                        end else if (held[3] && (p_up || p_down)) begin
                            sel_r <= p_down;
                            menu_r <= ADS_VIEW;
                        end
                    end
                    ADS_VIEW: begin
                        if (!held[3]) begin
                            menu_r <= ADS_OPER;
                        end else if (p_up || p_down) begin
                            sel_r <= ~sel_r;
                        end
                    end
                    ADS_CODE_PROMPT: begin
                        if (p_step) begin
                            menu_r <= ADS_CODE_EDIT;
                        end
                    end
                    ADS_CODE_EDIT: begin
                        if (p_enter) begin
                            menu_r <= (edit_r == code_r) ? ADS_SP_PROMPT : ADS_OPER;
                        end else if (p_step) begin
                            digit_r <= digit_r + 2'h1;
                        end else if (p_up || p_down) begin
                            edit_r <= bcd_adj(edit_r, digit_r, p_up);
                        end
                    end
                    ADS_SP_PROMPT: begin
                        if (p_enter) begin
                            menu_r <= ADS_OPER;
                        end else if (p_up || p_down) begin
                            sel_r <= ~sel_r;
                        end else if (p_step) begin
                            edit_r <= sp_r[sel_r];
                            digit_r <= 2'h0;
                            menu_r <= ADS_SP_EDIT;
                        end
                    end
                    ADS_SP_EDIT: begin
                        if (p_enter) begin
                            menu_r <= ADS_SP_PROMPT;
                        end else if (p_step) begin
                            digit_r <= digit_r + 2'h1;
                        end else if (p_up || p_down) begin
                            edit_r <= bcd_adj(edit_r, digit_r, p_up);
                        end
                    end
                    ADS_CFG_ACCESS_ENABLE: begin
                        if (p_enter) begin
                            o_setpoint_access_menu_done <= 1'b1;
                            menu_r <= ADS_OPER;
                        end else if (p_up || p_down) begin
                            menu_r <= ADS_CFG_CODE;
                        end else if (p_step) begin
                            en_edit_r <= access_en_r;
                            menu_r <= ADS_CFG_ACCESS_ENABLE_EDIT;
                        end
                    end
                    ADS_CFG_ACCESS_ENABLE_EDIT: begin
                        if (p_enter) begin
                            menu_r <= ADS_CFG_ACCESS_ENABLE;
                        end else if (p_up || p_down) begin
                            en_edit_r <= ~en_edit_r;
                        end
                    end
                    ADS_CFG_CODE: begin
                        if (p_enter) begin
                            o_setpoint_access_menu_done <= 1'b1;
                            menu_r <= ADS_OPER;
                        end else if (p_up || p_down) begin
                            menu_r <= ADS_CFG_ACCESS_ENABLE;
                        end else if (p_step) begin
                            edit_r <= code_r;
                            digit_r <= 2'h0;
                            menu_r <= ADS_CFG_CODE_EDIT;
                        end
                    end
                    ADS_CFG_CODE_EDIT: begin
                        if (p_enter) begin
                            menu_r <= ADS_CFG_CODE;
                        end else if (p_step) begin
                            digit_r <= digit_r + 2'h1;
                        end else if (p_up || p_down) begin
                            edit_r <= bcd_adj(edit_r, digit_r, p_up);
                        end
                    end
                    default: menu_r <= ADS_OPER;
                endcase
            end
        end
    end
    assign sp_store = (menu_r == ADS_SP_EDIT) && p_enter && !(idle_s_r >= `ADS_IDLE_TIMEOUT_S);
    assign code_store = (menu_r == ADS_CFG_CODE_EDIT) && p_enter;
    assign en_store = (menu_r == ADS_CFG_ACCESS_ENABLE_EDIT) && p_enter;

    // Display word; the flashing digit marks which one the buttons act on.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_disp <= '0;
        end else begin
            o_disp.menu <= menu_r;
            o_disp.sel_second <= sel_r;
            o_disp.value <= (menu_r == ADS_VIEW || menu_r == ADS_SP_PROMPT) ? sp_r[sel_r] :
                            (menu_r == ADS_CFG_ACCESS_ENABLE_EDIT) ? {15'h0000, en_edit_r} : edit_r;
            o_disp.digit <= digit_r;
            o_disp.digit_flash <= (menu_r == ADS_CODE_EDIT) || (menu_r == ADS_SP_EDIT) ||
                                  (menu_r == ADS_CFG_CODE_EDIT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: one write and one read at a time.
    logic aw_held_r, w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic wstrb_any_r;
    wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    wire rd_go = s_axi_arvalid && s_axi_arready;

    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Address and data are caught in either order and joined for the write.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_any_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_any_r <= |s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r[7:2] <= `ADS_REG_SP2 >> 2) ? `ADS_RESP_OKAY :
                               `ADS_RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Settings: operator stores win over a software write in the same cycle.
    // Byte strobes only gate the write: any set strobe writes the whole field, and all-zero strobes drop it.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            access_en_r <= `ADS_ENABLE_RESET;
            code_r <= `ADS_CODE_RESET;
            sense_r <= 2'h0;
            delay_r <= '{12'h0, 12'h0};
            sil_r <= '{12'h0, 12'h0};
            sp_r <= '{16'h0000, 16'h0000};
        end else begin
            if (wr_go && wstrb_any_r) begin
                unique case ({awaddr_r[7:2], 2'b00})
                    `ADS_REG_CTRL: begin
                        access_en_r <= wdata_r[`ADS_CTRL_ENABLE_BIT];
                        sense_r <= wdata_r[`ADS_CTRL_SENSE_LSB +: 2];
                    end
                    `ADS_REG_CODE: code_r <= wdata_r[15:0];
                    `ADS_REG_DELAY0: delay_r[0] <= clamp_s(wdata_r[15:0]);
                    `ADS_REG_DELAY1: delay_r[1] <= clamp_s(wdata_r[15:0]);
                    `ADS_REG_SIL0: sil_r[0] <= clamp_s(wdata_r[15:0]);
                    `ADS_REG_SIL1: sil_r[1] <= clamp_s(wdata_r[15:0]);
                    `ADS_REG_SP1: sp_r[0] <= wdata_r[15:0];
                    `ADS_REG_SP2: sp_r[1] <= wdata_r[15:0];
                    default: ;
                endcase
            end
            if (sp_store) begin
                sp_r[sel_r] <= edit_r;
            end
            if (code_store) begin
                code_r <= edit_r;
            end
            if (en_store) begin
                access_en_r <= en_edit_r;
            end
        end
    end

    // Read data is registered; unmapped addresses answer DECERR with zero.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ADS_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ADS_RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `ADS_REG_CTRL: s_axi_rdata <= {29'h0, sense_r, access_en_r};
                `ADS_REG_CODE: s_axi_rdata <= {16'h0, code_r};
                `ADS_REG_DELAY0: s_axi_rdata <= {20'h0, delay_r[0]};
                `ADS_REG_DELAY1: s_axi_rdata <= {20'h0, delay_r[1]};
                `ADS_REG_SIL0: s_axi_rdata <= {20'h0, sil_r[0]};
                `ADS_REG_SIL1: s_axi_rdata <= {20'h0, sil_r[1]};
                `ADS_REG_SP1: s_axi_rdata <= {16'h0, sp_r[0]};
                `ADS_REG_SP2: s_axi_rdata <= {16'h0, sp_r[1]};
                `ADS_REG_STATUS: s_axi_rdata <= {10'h0, menu_r, al_r[1], al_r[0],
                                                 o_annun_flash, o_alarm_out};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `ADS_RESP_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // ads_alarm_access
`default_nettype wire

// ### core/ads_defines.svh
// Constants for the alarm delay, silence and setpoint access block.
`ifndef ADS_DEFINES_SVH
`define ADS_DEFINES_SVH
`define ADS_CLK_PERIOD_NS 10
`define ADS_SECOND_NS 1000000000
`define ADS_TICK_CYCLES (`ADS_SECOND_NS / `ADS_CLK_PERIOD_NS)
`define ADS_MAX_SECONDS 12'hE10
`define ADS_IDLE_TIMEOUT_S 4'hA
`define ADS_REG_CTRL 8'h00
`define ADS_REG_CODE 8'h04
`define ADS_REG_DELAY0 8'h08
`define ADS_REG_DELAY1 8'h0C
`define ADS_REG_SIL0 8'h10
`define ADS_REG_SIL1 8'h14
`define ADS_REG_SP1 8'h18
`define ADS_REG_SP2 8'h1C
`define ADS_REG_STATUS 8'h20
`define ADS_CTRL_ENABLE_BIT 0
`define ADS_CTRL_SENSE_LSB 1
`define ADS_CODE_RESET 16'h0000
`define ADS_ENABLE_RESET 1'b0
`define ADS_RESP_OKAY 2'b00
`define ADS_RESP_DECERR 2'b11
`endif

// ### core/ads_pkg.sv
// Types shared by the alarm delay, silence and setpoint access block.
package ads_pkg;
    // Operator menu position, one-hot.
    typedef enum logic [9:0] {
        ADS_OPER = 10'h001,
        ADS_VIEW = 10'h002,
        ADS_CODE_PROMPT = 10'h004,
        ADS_CODE_EDIT = 10'h008,
        ADS_SP_PROMPT = 10'h010,
        ADS_SP_EDIT = 10'h020,
        ADS_CFG_ACCESS_ENABLE = 10'h040,
        ADS_CFG_ACCESS_ENABLE_EDIT = 10'h080,
        ADS_CFG_CODE = 10'h100,
        ADS_CFG_CODE_EDIT = 10'h200
    } ads_menu_t;
    // Per-alarm state, one-hot.
    typedef enum logic [3:0] {
        ADS_AL_IDLE = 4'h1,
        ADS_AL_PEND = 4'h2,
        ADS_AL_ACTIVE = 4'h4,
        ADS_AL_SILENCE = 4'h8
    } ads_alarm_t;
    // What the display shows.
    typedef struct packed {
        ads_menu_t menu;
        logic sel_second;
        logic [15:0] value;
        logic [1:0] digit;
        logic digit_flash;
    } ads_disp_t;
endpackage

// ### tb/ads_alarm_access_properties.sv
// Port checker for the alarm access block.
`timescale 1ns/100ps
`default_nettype none
module ads_chk import ads_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_btn_step,
    input wire logic i_btn_enter,
    input wire logic [1:0] o_annun_on,
    input wire logic [1:0] o_annun_flash,
    input wire ads_disp_t o_disp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // One clock domain, so clocking and reset are given once.
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    sequence view_left;
        $fell(i_btn_enter) && o_disp.menu == ADS_VIEW;
    endsequence
    AST_RST_OPER: assert property ($fell(i_reset) |=> o_disp.menu == ADS_OPER)
        else $error("menu not operating after reset");
    AST_FLASH_LIT: assert property ((o_annun_flash & ~o_annun_on) == 2'h0)
        else $error("flash without lit annunciator");
    AST_EDIT_FLASH: assert property (o_disp.menu == ADS_SP_EDIT |-> o_disp.digit_flash)
        else $error("edit digit not flashing");
    AST_VIEW_EXIT: assert property (view_left |-> ##[1:5] o_disp.menu == ADS_OPER)
        else $error("view kept after enter release");
    AST_SP_ENTRY: assert property ($rose(o_disp.menu == ADS_SP_PROMPT)
        && $past(o_disp.menu) == ADS_OPER |-> i_btn_step) else $error("prompt without step");
    AST_CODE_EXIT: assert property ($past(o_disp.menu) == ADS_CODE_EDIT
        && o_disp.menu != ADS_CODE_EDIT |-> o_disp.menu inside {ADS_OPER, ADS_SP_PROMPT})
        else $error("bad exit from code edit");
    AST_BRESP_HOLD: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
        else $error("write response dropped early");
    AST_RDATA_HOLD: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
        else $error("read data dropped early");
endmodule // ads_chk
bind ads_alarm_access ads_chk i_chk (.i_ref_clk, .i_reset, .i_btn_step, .i_btn_enter,
    .o_annun_on, .o_annun_flash, .o_disp, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
    .s_axi_rready);
`default_nettype wire

// ### tb/ads_operator.sv
// Operator model that presses a set of push buttons and lets them go.
`timescale 1ns/100ps
`default_nettype none
module ads_operator (
    input wire logic i_ref_clk,
    input wire logic i_go,
    input wire logic [3:0] i_keys,
    output logic [3:0] o_btn
);
    logic [4:0] cnt_r = 5'h00;
    // A press is held for nine cycles so the two-stage synchroniser sees it.
    always_ff @(posedge i_ref_clk) begin
        if (i_go) cnt_r <= 5'h10;
        else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
        o_btn <= (i_go || cnt_r > 5'h08) ? i_keys : 4'h0;
    end
endmodule // ads_operator
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the alarm delay, silence and access block.
`timescale 1ns/100ps
`default_nettype none
module testbench import ads_pkg::*; ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [3:0] keys = 4'h0;
    logic [3:0] btn;
    logic [1:0] cond = 2'h0;
    logic [7:0] aw = 8'h00;
    logic [31:0] wd = 32'h0;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, opn = 1'b0;
    logic awr, wr, bv, arr, rv, done;
    logic [1:0] bresp, rresp, aout, aon, afl, n_done = 2'h0;
    logic [31:0] rd;
    ads_disp_t disp;
    int n_fail = 0, tests_run = 0, cyc = 0;
    ads_operator i_op (.i_ref_clk(clk), .i_go(go), .i_keys(keys), .o_btn(btn));
    ads_alarm_access #(.TICK_CYCLES(20)) i_dut (.i_ref_clk(clk), .i_reset(rst),
        .i_btn_step(btn[3]), .i_btn_up(btn[2]), .i_btn_down(btn[1]), .i_btn_enter(btn[0]),
        .i_alarm_cond(cond), .i_setpoint_access_menu_open(opn), .o_setpoint_access_menu_done(done), .o_alarm_out(aout),
        .o_annun_on(aon), .o_annun_flash(afl), .o_disp(disp), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(aw), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
    // Clock at 100 MHz and a cycle ceiling that cuts a hang short.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (done) n_done <= n_done + 2'h1;
        if (cyc == 5000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // Ready is sampled at the falling edge; the handshake itself is the next rising edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r);
        logic [2:0] p;
        logic [2:0] t;
        p = w ? 3'h7 : 3'h5;
        @(posedge clk);
        aw <= a;
        wd <= d;
        {awv, wv, br} <= w ? 3'h7 : 3'h0;
        {arv, rr} <= w ? 2'h0 : 2'h3;
        while (p != 3'h0) begin
            @(negedge clk);
            t = p & (w ? {awr, wr, bv} : {arr, 1'b0, rv});
            if (t[0]) cmp(w ? bresp : rresp, r);
            if (t[0] && !w) cmp(rd, d);
            @(posedge clk);
            p = p & ~t;
            {awv, wv, br} <= w ? p : 3'h0;
            {arv, rr} <= w ? 2'h0 : {p[2], p[0]};
        end
    endtask
    task automatic press(input logic [3:0] k);
        @(posedge clk);
        keys <= k;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wt(20);
    endtask
    task automatic t_regs();
        bus(1'b0, 8'h00, 32'h0, 2'h0);
        bus(1'b0, 8'h04, 32'h0, 2'h0);
        bus(1'b0, 8'h24, 32'h0, 2'h3);
        bus(1'b1, 8'h20, 32'h1, 2'h3);
        bus(1'b1, 8'h08, 32'hFFF, 2'h0);
        bus(1'b0, 8'h08, 32'hE10, 2'h0);
        bus(1'b1, 8'h08, 32'h0, 2'h0);
        bus(1'b1, 8'h0C, 32'h2, 2'h0);
        bus(1'b1, 8'h10, 32'h2, 2'h0);
        bus(1'b0, 8'h10, 32'h2, 2'h0);
        $display("registers done");
    endtask
    // Alarm 0 has no delay and a silence time; alarm 1 waits two seconds.
    task automatic t_alarms();
        @(posedge clk);
        cond <= 2'h3;
        wt(3);
        cmp({aout, aon, afl}, 6'h1E);
        wt(45);
        cmp({aout, aon, afl}, 6'h3C);
        press(4'h8);
        cmp({disp.menu, aout, aon, afl}, {ADS_OPER, 6'h2D});
        wt(45);
        cmp({aout, aon, afl}, 6'h3C);
        @(posedge clk);
        cond <= 2'h0;
        wt(3);
        cmp({aout, aon, afl}, 6'h00);
        bus(1'b1, 8'h00, 32'h6, 2'h0);
        wt(2);
        cmp(aout, 2'h3);
        $display("alarms done");
    endtask
    task automatic t_access();
        press(4'hC);
        cmp(disp.menu, ADS_OPER);
        bus(1'b1, 8'h00, 32'h1, 2'h0);
        press(4'hC);
        cmp(disp.menu, ADS_SP_PROMPT);
        press(4'h4);
        cmp(disp.sel_second, 1'b1);
        press(4'h8);
        cmp({disp.menu, disp.digit_flash}, {ADS_SP_EDIT, 1'b1});
        press(4'h1);
        cmp(disp.menu, ADS_SP_PROMPT);
        press(4'h1);
        cmp(disp.menu, ADS_OPER);
        press(4'h5);
        cmp({disp.menu, disp.sel_second}, {ADS_OPER, 1'b0});
        bus(1'b1, 8'h04, 32'h1, 2'h0);
        press(4'hC);
        cmp(disp.menu, ADS_CODE_PROMPT);
        press(4'h8);
        press(4'h1);
        cmp(disp.menu, ADS_OPER);
        press(4'hC);
        press(4'h8);
        press(4'h4);
        press(4'h1);
        cmp(disp.menu, ADS_SP_PROMPT);
        wt(230);
        cmp(disp.menu, ADS_OPER);
        @(posedge clk);
        opn <= 1'b1;
        @(posedge clk);
        opn <= 1'b0;
        press(4'h4);
        cmp(disp.menu, ADS_CFG_CODE);
        press(4'h8);
        press(4'h4);
        press(4'h1);
        press(4'h1);
        cmp({disp.menu, n_done}, {ADS_OPER, 2'h1});
        bus(1'b0, 8'h04, 32'h2, 2'h0);
        $display("access done");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Reset for twelve cycles, then the scenarios in order.
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_alarms();
        t_access();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
